/* dbu_breakpoint_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module dbu_breakpoint_unit
  import dbu_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Instruction about to execute
  input  wire logic        instr_valid,
  input  wire logic [63:0] instr_addr,
  input  wire logic        instr_is_dr_access,
  // Data and I/O accesses of the executing instruction
  input  wire logic        mem_valid,
  input  wire logic [63:0] mem_addr,
  input  wire logic [1:0]  mem_len,
  input  wire logic        mem_write,
  input  wire logic        io_valid,
  input  wire logic [15:0] io_port,
  input  wire logic [1:0]  io_len,
  // Completion
  input  wire logic        retire_valid,
  input  wire logic [63:0] retire_addr,
  input  wire logic [63:0] retire_next_addr,
  input  wire logic        rep_iter_done,
  // Task switch and flags
  input  wire logic        task_switch_done,
  input  wire logic        task_trap_bit,
  input  wire logic [63:0] task_entry_addr,
  input  wire logic        resume_set,
  // Exception request
  output logic             dbg_exc,
  output logic [7:0]       dbg_vector,
  output logic             dbg_before,
  output logic [63:0]      dbg_ret_addr,
  output logic             resume_flag
);

  // Register state
  logic [31:0] slot_lo_ff [NUM_SLOTS];
  logic [31:0] slot_hi_ff [NUM_SLOTS];
  logic [31:0] ctrl_ff;
  logic [31:0] status_ff;
  logic        ext_en_ff;
  logic        resume_ff;
  logic [3:0]  pend_hits_ff;

  // Bus data phase state
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic        hresp_ff;

  // Exception outputs
  logic        dbg_exc_ff;
  logic        dbg_before_ff;
  logic [63:0] dbg_ret_addr_ff;
  logic [7:0]  dbg_vector_ff;

  // Comparator results
  logic [3:0]  fetch_hits;
  logic [3:0]  mem_hits;
  logic [3:0]  io_hits;
  logic [3:0]  cur_hits;
  logic [3:0]  pend_now;

  // Event decode
  logic        bus_take;
  logic        guard_en;
  logic        task_trap_evt;
  logic        data_fire;
  logic        after_fire;
  logic        fetch_fire;
  logic        guard_fire;
  logic        before_fire;
  logic [31:0] nxt_ctrl;
  logic [31:0] nxt_status;
  logic [31:0] nxt_rdata;
  logic [63:0] nxt_ret_addr;

  // Word-aligned offset inside the register window
  function automatic logic dbu_reg_ok(input logic [31:0] a);
    dbu_reg_ok = !(|a[31:8]) && !(|a[1:0]);
  endfunction

  // Per-slot comparators
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    logic [1:0] type_f;
    logic [1:0] size_f;
    assign type_f = ctrl_ff[CTRL_TYPE_LSB + i * CTRL_FIELD_STEP +: 2];
    assign size_f = ctrl_ff[CTRL_TYPE_LSB + i * CTRL_FIELD_STEP + 2 +: 2];
    dbu_slot_cmp u_cmp (
      .slot_addr  ({slot_hi_ff[i], slot_lo_ff[i]}),
      .acc_type   (type_f),
      .size_fld   (size_f),
      .armed      (ctrl_ff[2 * i] | ctrl_ff[2 * i + 1]),  // [RL5]
      .ext_en     (ext_en_ff),
      .fetch_addr (instr_addr),
      .mem_valid  (mem_valid),
      .mem_addr   (mem_addr),
      .mem_len    (mem_len),
      .mem_write  (mem_write),
      .io_valid   (io_valid),
      .io_port    (io_port),
      .io_len     (io_len),
      .fetch_hit  (fetch_hits[i]),
      .mem_hit    (mem_hits[i]),
      .io_hit     (io_hits[i])
    );
  end

  assign bus_take = hsel && hready && htrans[1];
  assign guard_en = ctrl_ff[CTRL_GUARD_BIT];

  // Exception decision
  always_comb begin
    cur_hits      = mem_hits | io_hits;
    pend_now      = pend_hits_ff | cur_hits;  // [RL25]
    task_trap_evt = task_switch_done && task_trap_bit;  // [RL18]
    data_fire     = (retire_valid || rep_iter_done) && (|pend_now);  // [RL17]
    after_fire    = task_trap_evt || data_fire;  // [RL2]
    // A completed instruction's condition wins; the next one is re-presented
    fetch_fire    = instr_valid && !after_fire && !resume_ff && (|fetch_hits);  // [RL3] [RL14]
    guard_fire    = instr_valid && !after_fire && instr_is_dr_access && guard_en;  // [RL20]
    before_fire   = fetch_fire || guard_fire;  // [RL2] [RL4]
  end

  // Return address selection
  always_comb begin
    if (task_trap_evt) begin
      nxt_ret_addr = task_entry_addr;  // [RL18]
    end else if (data_fire && rep_iter_done) begin
      nxt_ret_addr = retire_addr;  // [RL16]
    end else if (data_fire) begin
      nxt_ret_addr = retire_next_addr;  // [RL15]
    end else begin
      nxt_ret_addr = instr_addr;  // [RL13] [RL22]
    end
  end

  // Exception request register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_exc_ff    <= 1'b0;
      dbg_before_ff <= 1'b0;
    end else begin
      dbg_exc_ff    <= after_fire || before_fire;
      dbg_before_ff <= before_fire && !after_fire;
    end
  end

  // Return address, held until the next exception
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_ret_addr_ff <= 64'h0;
    end else if (after_fire || before_fire) begin
      dbg_ret_addr_ff <= nxt_ret_addr;
    end
  end

  // Vector number, the same for every cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_vector_ff <= DBG_VECTOR;
    end else begin
      dbg_vector_ff <= DBG_VECTOR;  // [RL1]
    end
  end

  // Hits seen during the executing instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_hits_ff <= 4'h0;
    end else if (data_fire || task_trap_evt) begin
      pend_hits_ff <= 4'h0;
    end else begin
      pend_hits_ff <= pend_now;
    end
  end

  // Resume flag: set wins over the retire clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume_ff <= 1'b0;
    end else if (resume_set) begin
      resume_ff <= 1'b1;
    end else if (retire_valid) begin
      resume_ff <= 1'b0;  // [RL14]
    end
  end

  // Control register next value
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_pend_ff && (wr_addr_ff == OFS_CTRL)) begin
      nxt_ctrl = hwdata;
    end
    if (task_switch_done) begin
      nxt_ctrl = nxt_ctrl & ~CTRL_LOCAL_MASK;  // [RL24]
    end
    if (guard_fire) begin
      nxt_ctrl[CTRL_GUARD_BIT] = 1'b0;  // [RL21]
    end
  end

  // Status register next value; hardware sets win over software writes
  always_comb begin
    nxt_status = status_ff;
    if (wr_pend_ff && (wr_addr_ff == OFS_STATUS)) begin
      nxt_status = hwdata;
    end
    if (data_fire) begin
      nxt_status[NUM_SLOTS-1:0] = nxt_status[NUM_SLOTS-1:0] | pend_now;  // [RL12] [RL25]
    end
    if (fetch_fire) begin
      nxt_status[NUM_SLOTS-1:0] = nxt_status[NUM_SLOTS-1:0] | fetch_hits;  // [RL12]
    end
    if (task_trap_evt) begin
      nxt_status[STAT_TASK_BIT] = 1'b1;  // [RL18]
    end
    if (guard_fire) begin
      nxt_status[STAT_REGACC_BIT] = 1'b1;  // [RL21]
    end
  end

  // Task trap bit is an input only and is never written back  [RL19]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Status flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= STAT_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Config register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_en_ff <= 1'b0;
    end else if (wr_pend_ff && (wr_addr_ff == OFS_CFG)) begin
      ext_en_ff <= hwdata[CFG_EXT_BIT];
    end
  end

  // Slot address registers, low word then high word per slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_lo_ff[i] <= 32'h0;
        slot_hi_ff[i] <= 32'h0;
      end
    end else if (wr_pend_ff && (wr_addr_ff < OFS_CTRL)) begin
      if (wr_addr_ff[2]) begin
        slot_hi_ff[wr_addr_ff[4:3]] <= hwdata;
      end else begin
        slot_lo_ff[wr_addr_ff[4:3]] <= hwdata;
      end
    end
  end

  // Read data mux, forwarding a write still in its data phase
  always_comb begin
    nxt_rdata = 32'h0;
    if (haddr[7:0] < OFS_CTRL) begin
      nxt_rdata = haddr[2] ? slot_hi_ff[haddr[4:3]] : slot_lo_ff[haddr[4:3]];
    end else begin
      case (haddr[7:0])
        OFS_CTRL:   nxt_rdata = ctrl_ff;
        OFS_STATUS: nxt_rdata = status_ff;
        OFS_CFG:    nxt_rdata = {31'h0, ext_en_ff};
        OFS_RESUME: nxt_rdata = {31'h0, resume_ff};
        default:    nxt_rdata = 32'h0;
      endcase
    end
    if (wr_pend_ff && (wr_addr_ff == haddr[7:0]) && (haddr[7:0] != OFS_RESUME)) begin
      nxt_rdata = hwdata;
    end
    if (!dbu_reg_ok(haddr)) begin
      nxt_rdata = 32'h0;
    end
  end

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h0;
      hrdata_ff  <= 32'h0;
    end else begin
      wr_pend_ff <= bus_take && hwrite && dbu_reg_ok(haddr);
      if (bus_take) begin
        wr_addr_ff <= haddr[7:0];
        if (!hwrite) begin
          hrdata_ff <= nxt_rdata;
        end
      end
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  // Response register, never an error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
    end
  end

  assign hreadyout    = hreadyout_ff;
  assign hrdata       = hrdata_ff;
  assign hresp        = hresp_ff;
  assign dbg_exc      = dbg_exc_ff;
  assign dbg_vector   = dbg_vector_ff;
  assign dbg_before   = dbg_before_ff;
  assign dbg_ret_addr = dbg_ret_addr_ff;
  assign resume_flag  = resume_ff;

endmodule
`default_nettype wire

/* dbu_pkg.sv */
// Function
// RL1: Every debug exception is delivered through vector number 1.
// RL2: Fetch and guard exceptions fire before execution; data, I/O, task after.
// RL3: Completed-instruction conditions outrank fetch and guard conditions on the next one.
// RL4: Fetch match on an instruction comes first, its data match after it.
// RL5: A slot is armed when its local or global enable bit is one.
// RL6: Type 00b compares only the next fetch address; software keeps size 00b.
// RL7: Type 01b matches memory writes only; 11b matches reads and writes.
// RL8: Data size 00b,01b,11b,10b give 1,2,4,8 bytes; 10b only in long mode.
// RL9: Type 10b matches I/O ports, only while the extension enable bit is one.
// RL10: I/O size 00b,01b,11b select byte, word, doubleword operations.
// RL11: I/O port address is zero-extended to 64 bits before compare.
// RL12: A slot match that raises the exception sets that slot's hit flag.
// RL13: Fetch match pushes the matched instruction's own address.
// RL14: Resume flag masks fetch matches for one instruction, then clears.
// RL15: Data match lets access finish and pushes the following instruction address.
// RL16: Unfinished repeated string match pushes the string instruction's own address.
// RL17: Repeated I/O strings report after each completed iteration while armed.
// RL18: Task switch into trapping task raises exception before first instruction, flags it.
// RL19: Task trap bit is never changed here; software clears it.
// RL20: Guard bit set makes any debug-register access raise the exception.
// RL21: Guard exception clears guard bit and sets register-access hit flag.
// RL22: Guard exception fires before the debug-register move executes.
// RL23: Size masks low slot bits; any accessed byte in range matches.
// RL24: Task switch clears all local enable bits, never global ones.
// RL25: All slots matching together set their hit flags in one update.
package dbu_pkg;

  localparam int unsigned NUM_SLOTS = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_SLOT_BASE = 8'h00;
  localparam logic [7:0] OFS_CTRL      = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;
  localparam logic [7:0] OFS_CFG       = 8'h28;
  localparam logic [7:0] OFS_RESUME    = 8'h2c;

  // Control register layout
  localparam int unsigned CTRL_GUARD_BIT   = 13;
  localparam int unsigned CTRL_TYPE_LSB    = 16;
  localparam int unsigned CTRL_FIELD_STEP  = 4;
  localparam logic [31:0] CTRL_LOCAL_MASK  = 32'h0000_0055;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // Status register layout
  localparam int unsigned STAT_REGACC_BIT  = 13;
  localparam int unsigned STAT_TASK_BIT    = 15;
  localparam logic [31:0] STAT_RESET       = 32'h0000_0000;

  // Config register layout
  localparam int unsigned CFG_EXT_BIT      = 0;

  // Access type encodings
  localparam logic [1:0] TYPE_EXEC  = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_IO    = 2'h2;
  localparam logic [1:0] TYPE_RW    = 2'h3;

  // Match size encodings
  localparam logic [1:0] SIZE_1B = 2'h0;
  localparam logic [1:0] SIZE_2B = 2'h1;
  localparam logic [1:0] SIZE_8B = 2'h2;
  localparam logic [1:0] SIZE_4B = 2'h3;

  localparam logic [7:0] DBG_VECTOR = 8'h01;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  // Low address bits ignored for a slot size
  function automatic logic [2:0] dbu_size_mask(input logic [1:0] sz);
    case (sz)
      SIZE_1B: dbu_size_mask = 3'h0;
      SIZE_2B: dbu_size_mask = 3'h1;
      SIZE_4B: dbu_size_mask = 3'h3;
      default: dbu_size_mask = 3'h7;
    endcase
  endfunction

  // Byte span minus one of an access, from log2 of its length
  function automatic logic [2:0] dbu_len_mask(input logic [1:0] len_log2);
    case (len_log2)
      2'h0:    dbu_len_mask = 3'h0;
      2'h1:    dbu_len_mask = 3'h1;
      2'h2:    dbu_len_mask = 3'h3;
      default: dbu_len_mask = 3'h7;
    endcase
  endfunction

  // Any byte of the access inside the slot range
  function automatic logic dbu_overlap(input logic [63:0] base, input logic [1:0] sz,
                                       input logic [63:0] acc, input logic [1:0] len_log2);
    logic [63:0] m;
    logic [63:0] r_lo;
    logic [63:0] r_hi;
    logic [63:0] a_hi;
    m    = {61'h0, dbu_size_mask(sz)};
    r_lo = base & ~m;
    r_hi = r_lo | m;
    a_hi = acc + {61'h0, dbu_len_mask(len_log2)};
    dbu_overlap = (acc <= r_hi) && (a_hi >= r_lo);
  endfunction

endpackage

/* dbu_slot_cmp.sv */
`timescale 1ns/1ns
`default_nettype none
module dbu_slot_cmp
  import dbu_pkg::*;
(
  // Slot setup
  input  wire logic [63:0] slot_addr,
  input  wire logic [1:0]  acc_type,
  input  wire logic [1:0]  size_fld,
  input  wire logic        armed,
  input  wire logic        ext_en,
  // Candidate accesses
  input  wire logic [63:0] fetch_addr,
  input  wire logic        mem_valid,
  input  wire logic [63:0] mem_addr,
  input  wire logic [1:0]  mem_len,
  input  wire logic        mem_write,
  input  wire logic        io_valid,
  input  wire logic [15:0] io_port,
  input  wire logic [1:0]  io_len,
  // Matches
  output logic             fetch_hit,
  output logic             mem_hit,
  output logic             io_hit
);

  logic [1:0] io_want_len;

  always_comb begin
    case (size_fld)
      SIZE_1B: io_want_len = 2'h0;
      SIZE_2B: io_want_len = 2'h1;
      SIZE_4B: io_want_len = 2'h2;
      default: io_want_len = 2'h3;
    endcase
  end

  always_comb begin
    fetch_hit = armed && (acc_type == TYPE_EXEC) &&
                dbu_overlap(slot_addr, SIZE_1B, fetch_addr, 2'h0);  // [RL6] [RL5]
    mem_hit   = armed && mem_valid &&
                ((acc_type == TYPE_RW) || ((acc_type == TYPE_WRITE) && mem_write)) &&  // [RL7]
                dbu_overlap(slot_addr, size_fld, mem_addr, mem_len);  // [RL8] [RL23]
    io_hit    = armed && io_valid && ext_en && (acc_type == TYPE_IO) &&  // [RL9]
                (io_len == io_want_len) &&  // [RL10]
                dbu_overlap(slot_addr, size_fld, {48'h0, io_port}, io_len);  // [RL11]
  end

endmodule
`default_nettype wire

/* dbu_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module dbu_properties (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Pipeline events
  input wire logic        instr_valid,
  input wire logic [63:0] instr_addr,
  input wire logic        instr_is_dr_access,
  input wire logic        retire_valid,
  input wire logic [63:0] retire_addr,
  input wire logic [63:0] retire_next_addr,
  input wire logic        rep_iter_done,
  input wire logic        task_switch_done,
  input wire logic        task_trap_bit,
  input wire logic [63:0] task_entry_addr,
  input wire logic        resume_set,
  // Exception request
  input wire logic        dbg_exc,
  input wire logic [7:0]  dbg_vector,
  input wire logic        dbg_before,
  input wire logic [63:0] dbg_ret_addr,
  input wire logic        resume_flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_trap;
    task_switch_done && task_trap_bit;
  endsequence
  sequence s_after;
    dbg_exc && !dbg_before;
  endsequence

  a_vector_fixed: assert property (dbg_exc |-> dbg_vector == 8'h01)
    else $error("debug vector wrong");
  a_task_trap: assert property (s_trap |=> s_after and dbg_ret_addr == $past(task_entry_addr))
    else $error("task trap not reported");
  a_after_cause: assert property (s_after |->
    $past(retire_valid || rep_iter_done || (task_switch_done && task_trap_bit)))
    else $error("after exception without completion");
  a_before_addr: assert property (dbg_exc && dbg_before |->
    $past(instr_valid) && dbg_ret_addr == $past(instr_addr))
    else $error("before exception address wrong");
  a_resume_mask: assert property (resume_flag && instr_valid && !instr_is_dr_access
    |=> !(dbg_exc && dbg_before))
    else $error("fetch match under resume flag");
  a_resume_clear: assert property (retire_valid && !resume_set |=> !resume_flag)
    else $error("resume flag not cleared");
  a_resume_load: assert property (resume_set |=> resume_flag)
    else $error("resume flag not set");
  a_rep_ret: assert property (rep_iter_done && !(task_switch_done && task_trap_bit)
    |=> !dbg_exc || dbg_before || dbg_ret_addr == $past(retire_addr))
    else $error("repeat return address wrong");
  a_data_ret: assert property (retire_valid && !rep_iter_done && !(task_switch_done && task_trap_bit)
    |=> !dbg_exc || dbg_before || dbg_ret_addr == $past(retire_next_addr))
    else $error("data return address wrong");
endmodule
`default_nettype wire

/* dbu_pipe_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dbu_pipe_model (
  // Clock
  input wire logic   hclk,
  // Event strobes
  output logic        instr_valid,
  output logic        instr_is_dr_access,
  output logic        mem_valid,
  output logic        mem_write,
  output logic        io_valid,
  output logic        retire_valid,
  output logic        rep_iter_done,
  output logic        task_switch_done,
  output logic        task_trap_bit,
  output logic        resume_set,
  // Addresses and lengths
  output logic [63:0] instr_addr,
  output logic [63:0] mem_addr,
  output logic [1:0]  mem_len,
  output logic [15:0] io_port,
  output logic [1:0]  io_len,
  output logic [63:0] retire_addr,
  output logic [63:0] retire_next_addr,
  output logic [63:0] task_entry_addr
);
  logic [9:0]  ctl_q = 10'h0;
  logic [63:0] a_q   = 64'h0;
  logic [63:0] b_q   = 64'h0;
  logic [1:0]  l_q   = 2'h0;

  assign {instr_valid, instr_is_dr_access, mem_valid, mem_write, io_valid, retire_valid,
          rep_iter_done, task_switch_done, task_trap_bit, resume_set} = ctl_q;
  assign instr_addr       = a_q;
  assign mem_addr         = a_q;
  assign io_port          = a_q[15:0];
  assign retire_addr      = a_q;
  assign task_entry_addr  = a_q;
  assign retire_next_addr = b_q;
  assign mem_len          = l_q;
  assign io_len           = l_q;

  // One cycle of events; trap bit is the task's own and never altered here
  task issue(input logic [9:0] f, input logic [63:0] a, input logic [63:0] b,
             input logic [1:0] len);
    @(posedge hclk);
    ctl_q <= f;
    a_q   <= a;
    b_q   <= b;
    l_q   <= len;
    @(posedge hclk);
    ctl_q <= 10'h0;
    // Released lines show no stale value
    a_q   <= ~a;
    b_q   <= ~b;
    l_q   <= ~len;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dbu_pkg::*;
  localparam logic [9:0] F_IV = 10'h200, F_DR = 10'h100, F_MV = 10'h080, F_MW = 10'h040;
  localparam logic [9:0] F_IO = 10'h020, F_RV = 10'h010, F_REP = 10'h008, F_TS = 10'h004;
  localparam logic [9:0] F_TT = 10'h002, F_RS = 10'h001;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, mem_len, io_len;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, dbg_exc, dbg_before, resume_flag, instr_valid, mem_valid;
  logic        instr_is_dr_access, mem_write, io_valid, retire_valid, rep_iter_done;
  logic        task_switch_done, task_trap_bit, resume_set;
  logic [7:0]  dbg_vector;
  logic [15:0] io_port;
  logic [63:0] dbg_ret_addr, instr_addr, mem_addr, retire_addr, retire_next_addr;
  logic [63:0] task_entry_addr;
  wire logic   hready;
  int          bad_count = 0, checks = 0;

  assign hready = hreadyout;
  always #4 hclk = ~hclk;

  dbu_breakpoint_unit dbu_breakpoint_unit_inst (.*);
  dbu_pipe_model dbu_pipe_model_inst (.*);

  task results;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  task ev(input logic [9:0] f, input logic [63:0] a, input logic [63:0] b, input logic [1:0] l,
          input logic e, input logic bf, input logic [63:0] ret);
    dbu_pipe_model_inst.issue(f, a, b, l);
    #1;
    chk(dbg_exc, e);
    if (e) begin
      chk(dbg_before, bf);
      chk(dbg_ret_addr, ret);
      chk(dbg_vector, 8'h01);
    end
  endtask

  task t_fetch;
    wr(32'h00, 32'h1000);
    wr(32'h08, 32'h1000);
    wr(32'h20, 32'h6);
    ev(F_IV, 64'h1001, 0, 0, 0, 0, 0);
    ev(F_IV, 64'h1000, 0, 0, 1, 1, 64'h1000);
    rdc(32'h24, 32'h3);
    ev(F_RS, 0, 0, 0, 0, 0, 0);
    chk(resume_flag, 1'b1);
    rdc(32'h2c, 32'h1);
    ev(F_IV, 64'h1000, 0, 0, 0, 0, 0);
    ev(F_RV, 64'h1000, 64'h1004, 0, 0, 0, 0);
    chk(resume_flag, 1'b0);
    ev(F_IV, 64'h1000, 0, 0, 1, 1, 64'h1000);
  endtask

  task drow(input logic [31:0] c, input logic [31:0] s, input logic [63:0] a,
            input logic [1:0] l, input logic w, input logic hit);
    wr(32'h00, s);
    wr(32'h20, c);
    ev(F_MV | (w ? F_MW : 10'h0) | F_RV, a, 64'h2000, l, hit, 0, 64'h2000);
  endtask

  task t_data;
    wr(32'h24, 32'h0);
    drow(32'h000d_0002, 32'h1004, 64'h1004, 2, 0, 0);
    drow(32'h000d_0002, 32'h1004, 64'h1002, 2, 1, 1);
    drow(32'h000d_0002, 32'h1004, 64'h1008, 0, 1, 0);
    drow(32'h000d_0002, 32'h1004, 64'h1000, 2, 1, 0);
    drow(32'h0003_0002, 32'h1001, 64'h1000, 1, 0, 1);
    drow(32'h0003_0002, 32'h1001, 64'h1002, 0, 0, 0);
    drow(32'h0007_0002, 32'h1002, 64'h1003, 0, 1, 1);
    drow(32'h0007_0002, 32'h1002, 64'h1004, 0, 1, 0);
    // Eight-byte size assumes long mode is active
    drow(32'h000b_0002, 32'h1005, 64'h1007, 0, 1, 1);
    drow(32'h000b_0002, 32'h1005, 64'h0ffe, 1, 1, 0);
    drow(32'h000b_0002, 32'h1005, 64'h0ffe, 2, 1, 1);
    rdc(32'h24, 32'h1);
    ev(F_MV | F_MW | F_REP, 64'h1000, 0, 0, 1, 0, 64'h1000);
    wr(32'h20, 32'h000b_0006);
    ev(F_IV, 64'h1000, 0, 0, 1, 1, 64'h1000);
    ev(F_MV | F_MW | F_RV, 64'h1000, 64'h2000, 0, 1, 0, 64'h2000);
    ev(F_MV | F_MW | F_RV | F_IV, 64'h1000, 64'h2000, 0, 1, 0, 64'h2000);
  endtask

  task t_io;
    wr(32'h24, 32'h0);
    wr(32'h10, 32'h60);
    wr(32'h20, 32'h0200_0020);
    ev(F_IO | F_RV, 64'h60, 64'h70, 0, 0, 0, 0);
    wr(32'h28, 32'h1);
    ev(F_IO | F_RV, 64'h60, 64'h70, 0, 1, 0, 64'h70);
    ev(F_IO | F_RV, 64'h60, 64'h70, 1, 0, 0, 0);
    ev(F_IO | F_REP, 64'h60, 0, 0, 1, 0, 64'h60);
    ev(F_IO | F_REP, 64'h60, 0, 0, 1, 0, 64'h60);
    rdc(32'h24, 32'h4);
    wr(32'h20, 32'h0600_0020);
    ev(F_IO | F_RV, 64'h60, 64'h70, 1, 1, 0, 64'h70);
    wr(32'h20, 32'h0e00_0020);
    ev(F_IO | F_RV, 64'h60, 64'h70, 2, 1, 0, 64'h70);
    wr(32'h14, 32'h1);
    ev(F_IO | F_RV, 64'h60, 64'h70, 2, 0, 0, 0);
  endtask

  task t_task_guard;
    wr(32'h24, 32'h0);
    wr(32'h20, 32'h9);
    ev(F_TS | F_TT, 64'h5000, 0, 0, 1, 0, 64'h5000);
    rdc(32'h20, 32'h8);
    rdc(32'h24, 32'h8000);
    ev(F_TS, 64'h5000, 0, 0, 0, 0, 0);
    wr(32'h24, 32'h0);
    wr(32'h20, 32'h2000);
    ev(F_IV | F_DR, 64'h7000, 0, 0, 1, 1, 64'h7000);
    rdc(32'h20, 32'h0);
    rdc(32'h24, 32'h2000);
    ev(F_IV | F_DR, 64'h7000, 0, 0, 0, 0, 0);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    chk({hreadyout, hresp, dbg_exc, resume_flag, dbg_vector}, {4'h8, 8'h01});
    hresetn <= 1'b1;
    t_fetch;
    t_data;
    t_io;
    t_task_guard;
    results;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    results;
  end
endmodule

bind dbu_breakpoint_unit dbu_properties dbu_properties_inst (.*);
`default_nettype wire
